// ### rtl/lsf_idle_timer.v
// Idle-timeout counter for the LIN status-flag block.
// Assumes activity and sleep levels synchronous to aclk.
`timescale 1ns/1ps
`include "lsf_consts.vh"
module lsf_idle_timer #(
  parameter [31:0] IDLE_CYCLES = `LSF_IDLE_CYCLES
) (
  input  wire aclk,
  input  wire aresetn,
  input  wire enable,
  input  wire bus_active,
  input  wire bus_asleep,
  output reg  timed_out
);

  reg [31:0] count;

  // Counter saturates at the limit so it never wraps back below it
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      count     <= 32'h00000000;
      timed_out <= 1'b0;
    end
    else if (!enable || bus_active || bus_asleep)
    begin
      count     <= 32'h00000000;
      timed_out <= 1'b0;
    end
    else if (count >= IDLE_CYCLES - 32'h00000001)
    begin
      timed_out <= 1'b1;
    end
    else
    begin
      count <= count + 32'h00000001;
    end
  end

endmodule

// ### rtl/lsf_status_regs.v
// LIN status-flag register bank with AXI4-Lite slave.
// Assumes frame engine and bus monitor give one-cycle event pulses and levels on aclk.
`timescale 1ns/1ps
`include "lsf_consts.vh"
module lsf_status_regs #(
  parameter [31:0] IDLE_CYCLES = `LSF_IDLE_CYCLES
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [5:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [5:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        bus_active,
  input  wire        break_seen,
  input  wire        frame_start,
  input  wire        frame_end,
  input  wire        data_id_seen,
  input  wire        irq_event,
  input  wire [4:0]  fault_event,
  input  wire        wake_sending,
  input  wire        wake_received,
  input  wire        bus_asleep,
  output reg         slave_mode,
  output reg         sleep_enable,
  output reg         halt_active,
  output reg  [7:0]  lin_status_out
);

  ////////////////////////////////////////////////////////////////////////
  // Flag state
  reg        idle_timeout_flag;
  reg        abort_flag;
  reg        data_request_flag;
  reg        irq_pending_flag;
  reg        fault_flag;
  reg        wake_flag;
  reg        done_flag;
  reg        in_frame;
  reg  [4:0] lin_fault_detail;
  reg        wake_rx_held;
  wire [4:0] next_fault_detail;
  wire       idle_hit;
  wire [7:0] lin_status;

  // Write channel capture
  reg        aw_held;
  reg        w_held;
  reg  [5:0] aw_addr;
  reg  [31:0] w_data;
  reg  [3:0] w_strb;
  wire       do_write;
  wire       wr_ctrl;
  wire       wr_ev;
  wire       irq_clear_bit;
  wire       fault_clear_bit;
  wire       halt_write;

  assign do_write        = aw_held && w_held && !s_axi_bvalid;
  assign wr_ctrl         = do_write && aw_addr == `LSF_ADDR_CONTROL && w_strb[0];
  assign wr_ev           = do_write && aw_addr == `LSF_ADDR_EVENTS && w_strb[0];
  assign irq_clear_bit   = wr_ctrl && w_data[`LSF_CT_IRQ_CLR];
  assign fault_clear_bit = wr_ctrl && w_data[`LSF_CT_FAULT_CLR];
  assign halt_write      = wr_ctrl && w_data[`LSF_CT_HALT] && slave_mode;

  ////////////////////////////////////////////////////////////////////////
  // Idle timer
  // idle timeout count
  lsf_idle_timer #(
    .IDLE_CYCLES (IDLE_CYCLES)
  ) u_idle (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .enable     (slave_mode),
    .bus_active (bus_active),
    .bus_asleep (bus_asleep),
    .timed_out  (idle_hit)
  );

  ////////////////////////////////////////////////////////////////////////
  // Status flags, one register each
  // every flag resets to zero
  always @(posedge aclk)
  begin
    if (!aresetn)
      idle_timeout_flag <= 1'b0;
    else
      idle_timeout_flag <= slave_mode && idle_hit && !bus_asleep;
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
      abort_flag <= 1'b0;
    else if (slave_mode && ((break_seen && in_frame) || halt_write))
      abort_flag <= 1'b1;
    // clean break clears; never shown outside slave mode
    else if (!slave_mode || (break_seen && !in_frame))
      abort_flag <= 1'b0;
  end

  // halt until break; a halt written with a break still holds
  always @(posedge aclk)
  begin
    if (!aresetn)
      halt_active <= 1'b0;
    else if (halt_write)
      halt_active <= 1'b1;
    else if (break_seen)
      halt_active <= 1'b0;
  end

  // data identifier request; a new frame rearms it
  always @(posedge aclk)
  begin
    if (!aresetn)
      data_request_flag <= 1'b0;
    else if (slave_mode && data_id_seen)
      data_request_flag <= 1'b1;
    else if (frame_start || !slave_mode)
      data_request_flag <= 1'b0;
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
      irq_pending_flag <= 1'b0;
    else if (irq_event)
      irq_pending_flag <= 1'b1;
    else if (irq_clear_bit)
      irq_pending_flag <= 1'b0;
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
      fault_flag <= 1'b0;
    else if (|fault_event)
      fault_flag <= 1'b1;
    else if (fault_clear_bit)
      fault_flag <= 1'b0;
  end

  // fault detail per bit; a new fault wins over the clear
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1)
    begin : g_fault
      assign next_fault_detail[gi] = fault_event[gi] | (lin_fault_detail[gi] & !fault_clear_bit);
    end
  endgenerate

  always @(posedge aclk)
  begin
    if (!aresetn)
      lin_fault_detail <= 5'h00;
    else
      lin_fault_detail <= next_fault_detail;
  end

  // a received wakeup holds until the bus moves again
  always @(posedge aclk)
  begin
    if (!aresetn)
      wake_rx_held <= 1'b0;
    else if (wake_received)
      wake_rx_held <= 1'b1;
    else if (frame_start || bus_active)
      wake_rx_held <= 1'b0;
  end

  // high while sending or while a received wakeup is held, so it drops when both have ended
  always @(posedge aclk)
  begin
    if (!aresetn)
      wake_flag <= 1'b0;
    else
      wake_flag <= wake_sending || wake_received || (wake_rx_held && !frame_start && !bus_active);
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
      done_flag <= 1'b0;
    else if (frame_end)
      done_flag <= 1'b1;
    else if (frame_start)
      done_flag <= 1'b0;
  end

  // Frame window tells an abort from a clean break
  always @(posedge aclk)
  begin
    if (!aresetn)
      in_frame <= 1'b0;
    else if (frame_start)
      in_frame <= 1'b1;
    else if (frame_end)
      in_frame <= 1'b0;
  end

  assign lin_status = {bus_active, idle_timeout_flag, abort_flag, data_request_flag,
                       irq_pending_flag, fault_flag, wake_flag, done_flag};

  always @(posedge aclk)
  begin
    if (!aresetn)
      lin_status_out <= `LSF_RESET_BYTE;
    else
      lin_status_out <= lin_status;
  end

  ////////////////////////////////////////////////////////////////////////
  // Configuration bits held by the bank
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      slave_mode   <= 1'b0;
      sleep_enable <= 1'b0;
    end
    else
    begin
      if (wr_ev)
        slave_mode <= w_data[`LSF_EV_SLAVE];
      if (wr_ctrl)
        sleep_enable <= w_data[`LSF_CT_SLEEP];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write path; address and data taken in either order
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 6'h00;
      w_data        <= 32'h00000000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `LSF_RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_held && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (aw_addr == `LSF_ADDR_CONTROL || aw_addr == `LSF_ADDR_EVENTS ||
            aw_addr == `LSF_ADDR_STATUS || aw_addr == `LSF_ADDR_FAULT)
          s_axi_bresp <= `LSF_RESP_OKAY;
        else
          s_axi_bresp <= `LSF_RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read path
  reg [31:0] next_rdata;
  reg [1:0]  next_rresp;

  always @*
  begin
    next_rdata = 32'h00000000;
    next_rresp = `LSF_RESP_OKAY;
    case (s_axi_araddr)
      `LSF_ADDR_CONTROL: next_rdata = {24'h000000, 1'b0, sleep_enable, 6'h00};
      `LSF_ADDR_STATUS:  next_rdata = {24'h000000, lin_status};
      `LSF_ADDR_FAULT:   next_rdata = {27'h0000000, lin_fault_detail};
      `LSF_ADDR_EVENTS:  next_rdata = {30'h00000000, halt_active, slave_mode};
      default:           next_rresp = `LSF_RESP_SLVERR;
    endcase
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `LSF_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= next_rdata;
        s_axi_rresp  <= next_rresp;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// ### shared/lsf_consts.vh
// Constants of the LIN status-flag block: register indices, bit positions, reset values, timing.
// Included by the design files; definitions only.
`ifndef LSF_CONSTS_VH
`define LSF_CONSTS_VH

// Printed register indices (byte address is four times the index)
`define LSF_IDX_CONTROL     8'h08
`define LSF_IDX_STATUS      8'h09
`define LSF_IDX_FAULT       8'h0a
`define LSF_IDX_EVENTS      8'h0f
`define LSF_ADDR_CONTROL    6'h20
`define LSF_ADDR_STATUS     6'h24
`define LSF_ADDR_FAULT      6'h28
`define LSF_ADDR_EVENTS     6'h3c

// Status bit positions
`define LSF_ST_ACTIVE       7
`define LSF_ST_IDLE         6
`define LSF_ST_ABORT        5
`define LSF_ST_DREQ         4
`define LSF_ST_IRQ          3
`define LSF_ST_ERR          2
`define LSF_ST_WAKE         1
`define LSF_ST_DONE         0

// Control bit positions
`define LSF_CT_HALT         7
`define LSF_CT_SLEEP        6
`define LSF_CT_IRQ_CLR      3
`define LSF_CT_FAULT_CLR    2

// Extra configuration register bit
`define LSF_EV_SLAVE        0

`define LSF_RESET_BYTE      8'h00

// Idle timeout: four seconds at 50 MHz
`define LSF_IDLE_TIME_S     4
`define LSF_CLK_HZ          50000000
`define LSF_IDLE_CYCLES     (`LSF_IDLE_TIME_S * `LSF_CLK_HZ)

// AXI response codes
`define LSF_RESP_OKAY       2'h0
`define LSF_RESP_SLVERR     2'h2

`endif

// ### tb/lsf_lin_model.sv
// Stand-in for the frame engine and bus monitor.
// Assumes the bench calls its tasks; outputs change after rising edges.
`timescale 1ns/1ps
module lsf_lin_model (
  input wire       aclk,
  output reg       bus_active,
  output reg       break_seen,
  output reg       frame_start,
  output reg       frame_end,
  output reg       data_id_seen,
  output reg       irq_event,
  output reg       wake_received,
  output reg [4:0] fault_event,
  output reg       wake_sending,
  output reg       bus_asleep
);
  initial {bus_active, wake_sending, bus_asleep, break_seen, frame_start, frame_end, data_id_seen,
    irq_event, wake_received, fault_event} = 14'h0000;
  // Events last exactly one cycle, as the engine gives them
  task pulse(input [10:0] v);
    begin
      @(posedge aclk);
      {break_seen, frame_start, frame_end, data_id_seen, irq_event, wake_received, fault_event} <= v;
      @(posedge aclk);
      {break_seen, frame_start, frame_end, data_id_seen, irq_event, wake_received, fault_event} <= 11'h000;
    end
  endtask
  task level(input [2:0] v);
    begin
      @(posedge aclk);
      {bus_active, wake_sending, bus_asleep} <= v;
    end
  endtask
endmodule

// ### tb/lsf_status_regs_asserts.sv
// Port checker for the LIN status-flag bank.
// Assumes events show on lin_status_out two edges later.
`timescale 1ns/1ps
module lsf_status_regs_asserts #(
  parameter [31:0] IDLE_CYCLES = 32'd20
) (
  input wire       aclk,
  input wire       aresetn,
  input wire       frame_start,
  input wire       frame_end,
  input wire       irq_event,
  input wire [4:0] fault_event,
  input wire       wake_sending,
  input wire       bus_active,
  input wire       break_seen,
  input wire       slave_mode,
  input wire       halt_active,
  input wire [7:0] lin_status_out
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_flags_reset: assert property ($rose(aresetn) |-> lin_status_out == 8'h00)
    else $error("flags not clear after reset");
  a_done_set: assert property (frame_end && !frame_start |-> ##2 lin_status_out[0])
    else $error("done flag missing");
  a_done_clear: assert property (frame_start && !frame_end |-> ##2 !lin_status_out[0])
    else $error("done flag kept");
  a_irq_set: assert property (irq_event |-> ##2 lin_status_out[3])
    else $error("irq flag missing");
  a_err_set: assert property (|fault_event |-> ##2 lin_status_out[2])
    else $error("error flag missing");
  a_wake_send: assert property (wake_sending && !bus_active && !frame_start |-> ##2 lin_status_out[1])
    else $error("wake flag missing");
  a_slave_only: assert property (!slave_mode |-> ##2 lin_status_out[6:4] == 3'b000)
    else $error("slave flag in master mode");
  a_halt_break: assert property (halt_active && break_seen |=> !halt_active)
    else $error("halt kept past break");
  a_active_follow: assert property ($past(aresetn) |-> lin_status_out[7] == $past(bus_active))
    else $error("activity bit not following bus");
  cover property (slave_mode && !bus_active ##1 lin_status_out[6]);
  cover property (frame_end ##2 lin_status_out[0]);
  cover property (irq_event ##2 lin_status_out[3]);
  cover property (halt_active && break_seen);
endmodule

bind lsf_status_regs lsf_status_regs_asserts #(.IDLE_CYCLES(IDLE_CYCLES)) chk (.aclk, .aresetn, .frame_start,
  .frame_end, .irq_event, .fault_event, .wake_sending, .bus_active, .break_seen, .slave_mode, .halt_active,
  .lin_status_out);

// ### tb/lsf_status_regs_tb.sv
// Bench for the LIN status-flag bank over AXI4-Lite.
// Assumes the event model and a short idle count of 20 cycles.
`timescale 1ns/1ps
`include "lsf_consts.vh"
module lsf_status_regs_tb;
  reg         aclk;
  reg         aresetn;
  reg  [5:0]  s_axi_awaddr;
  reg  [5:0]  s_axi_araddr;
  reg  [31:0] s_axi_wdata;
  reg  [3:0]  s_axi_wstrb;
  reg         s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire        bus_active, break_seen, frame_start, frame_end, data_id_seen, irq_event;
  wire        wake_received, wake_sending, bus_asleep, slave_mode, sleep_enable, halt_active;
  wire [4:0]  fault_event;
  wire [7:0]  lin_status_out;
  integer     err_total, n_compared, cyc, tn;
  localparam [10:0] BRK = 11'h400, ST = 11'h200, FIN = 11'h100, ID = 11'h080, IRQ = 11'h040, WK = 11'h020;
  localparam [5:0] S = `LSF_ADDR_STATUS, C = `LSF_ADDR_CONTROL, F = `LSF_ADDR_FAULT, E = `LSF_ADDR_EVENTS;
  lsf_status_regs #(.IDLE_CYCLES(32'd20)) uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .bus_active, .break_seen, .frame_start, .frame_end, .data_id_seen, .irq_event, .fault_event,
    .wake_sending, .wake_received, .bus_asleep, .slave_mode, .sleep_enable, .halt_active, .lin_status_out);
  lsf_lin_model m (.aclk, .bus_active, .break_seen, .frame_start, .frame_end, .data_id_seen, .irq_event,
    .wake_received, .fault_event, .wake_sending, .bus_asleep);
  initial
  begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  task wrap_up;
    begin
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      err_total = err_total + 1;
      wrap_up;
    end
  end
  task chk(input [31:0] g, input [31:0] e);
    begin
      n_compared = n_compared + 1;
      if (g !== e)
      begin
        err_total = err_total + 1;
        $display("FAIL t=%0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  task wr(input [5:0] a, input [7:0] d, input [1:0] er);
    begin
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (1)
      begin
        @(posedge aclk);
        if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
        if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        if (s_axi_bvalid === 1'b1) break;
      end
      s_axi_bready <= 1'b0;
      chk({30'h0, s_axi_bresp}, {30'h0, er});
    end
  endtask
  // Response always checked; data only where the access is mapped
  task rd(input [5:0] a, input [1:0] er, input [7:0] e);
    begin
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (1)
      begin
        @(posedge aclk);
        if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        if (s_axi_rvalid === 1'b1) break;
      end
      s_axi_rready <= 1'b0;
      chk({30'h0, s_axi_rresp}, {30'h0, er});
      if (er == 2'h0) chk(s_axi_rdata, {24'h0, e});
    end
  endtask
  task tend;
    begin
      tn = tn + 1;
      $display("test %0d done", tn);
    end
  endtask
  initial
  begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 44'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_wstrb = 4'hf;
    {err_total, n_compared, cyc, tn} = 0;
    aresetn = 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(S, 2'h0, 8'h00);
    wr(S, 8'hff, 2'h0);
    rd(S, 2'h0, 8'h00);
    rd(6'h2c, 2'h2, 8'h00);
    wr(6'h2c, 8'h01, 2'h2);
    tend;
    m.level(3'b100);
    rd(S, 2'h0, 8'h80);
    m.level(3'b000);
    rd(S, 2'h0, 8'h00);
    m.pulse(ST);
    m.pulse(FIN);
    rd(S, 2'h0, 8'h01);
    m.pulse(ST);
    rd(S, 2'h0, 8'h00);
    tend;
    m.pulse(IRQ);
    rd(S, 2'h0, 8'h08);
    s_axi_wstrb <= 4'h0;
    wr(C, 8'h08, 2'h0);
    s_axi_wstrb <= 4'hf;
    rd(S, 2'h0, 8'h08);
    wr(C, 8'h08, 2'h0);
    rd(S, 2'h0, 8'h00);
    m.pulse(11'h01f);
    rd(S, 2'h0, 8'h04);
    rd(F, 2'h0, 8'h1f);
    wr(C, 8'h44, 2'h0);
    rd(C, 2'h0, 8'h40);
    chk({31'h0, sleep_enable}, 32'h1);
    rd(S, 2'h0, 8'h00);
    rd(F, 2'h0, 8'h00);
    tend;
    m.pulse(WK);
    rd(S, 2'h0, 8'h02);
    m.pulse(ST);
    m.level(3'b010);
    rd(S, 2'h0, 8'h02);
    m.level(3'b000);
    rd(S, 2'h0, 8'h00);
    m.pulse(ST);
    m.pulse(ID);
    rd(S, 2'h0, 8'h00);
    tend;
    m.level(3'b100);
    wr(E, 8'h01, 2'h0);
    m.pulse(ID);
    rd(S, 2'h0, 8'h90);
    m.pulse(ST);
    m.pulse(BRK);
    rd(S, 2'h0, 8'ha0);
    m.pulse(FIN);
    m.pulse(BRK);
    rd(S, 2'h0, 8'h81);
    chk({24'h0, lin_status_out}, 32'h81);
    wr(C, 8'h80, 2'h0);
    rd(S, 2'h0, 8'ha1);
    rd(E, 2'h0, 8'h03);
    chk({30'h0, halt_active, slave_mode}, 32'h3);
    m.pulse(BRK);
    rd(E, 2'h0, 8'h01);
    tend;
    m.level(3'b000);
    rd(S, 2'h0, 8'h01);
    repeat (25) @(posedge aclk);
    rd(S, 2'h0, 8'h41);
    m.level(3'b001);
    rd(S, 2'h0, 8'h01);
    tend;
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(S, 2'h0, 8'h00);
    rd(E, 2'h0, 8'h00);
    chk({24'h0, lin_status_out}, 32'h0);
    tend;
    wrap_up;
  end
endmodule
